/* File: inc/qdec_params.svh */
// How it works
// - mode 1 decode: up/down chosen from which input moved and the other's level
// - one count per edge of either input, four counts per encoder cycle
// - position counts only from encoder input edges, never from a prescaler
// - a select bit switches counting to the alternate input pin pair
// - index rising edge captures position and clears the counter together
// - every index capture raises the index capture flag
// - reference compare match latches position into the periodic capture register
// - every periodic capture raises the periodic capture flag
// - reference counter clears on period compare match, one match per 1 ms
// - reference counter advances every second ref_clk cycle (REF_DIV), the 50 MHz peripheral rate
// - each position count latches reference count into edge capture, raising a flag
// - each edge capture moves the old edge capture value into its buffer
// - separate overflow and underflow flags when the position counter wraps
// - position and reference counters and capture registers are sixteen bits wide; the divider is eight
`ifndef QDEC_PARAMS_SVH
`define QDEC_PARAMS_SVH

`define ADDR_W 8
`define CNT_W 16
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_MASK 8'h08
`define OFS_POSITION 8'h0C
`define OFS_INDEX_CAP 8'h10
`define OFS_PERIODIC_CAP 8'h14
`define OFS_REFERENCE 8'h18
`define OFS_PERIOD_CMP 8'h1C
`define OFS_EDGE_CAP 8'h20
`define OFS_EDGE_BUF 8'h24

`define CTRL_RST 3'h0
`define FLAGS_RST 5'h00
`define FLAGS_W 5
`define CTRL_W 3

`define SYS_CLK_HZ 100000000
`define REF_CLK_HZ 50000000
`define REF_DIV (`SYS_CLK_HZ / `REF_CLK_HZ)
`define CAPTURE_PERIOD_US 1000
`define PERIOD_CMP_RST ((`REF_CLK_HZ / 1000000) * `CAPTURE_PERIOD_US - 1)

`endif

/* File: inc/qdec_pkg.sv */
`include "qdec_params.svh"

package qdec_pkg;

  typedef logic [`CNT_W-1:0] count_t;

  // control bits, msb first: reference enable, pin pair select, position enable
  typedef struct packed {
    logic ref_en;
    logic alt_sel;
    logic pos_en;
  } ctrl_t;

  // sticky event bits, shared by status and mask
  typedef struct packed {
    logic edge_cap;
    logic underflow;
    logic overflow;
    logic periodic;
    logic index;
  } flags_t;

  typedef struct packed {
    logic a;
    logic b;
  } phase_t;

  typedef struct packed {
    logic up;
    logic down;
  } step_t;

endpackage

/* File: rtl/quadrature_counter_index_capture.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qdec_params.svh"

module quadrature_counter_index_capture
  import qdec_pkg::*;
#(
  parameter logic [`CNT_W-1:0] PERIOD_CMP_RESET = `CNT_W'(`PERIOD_CMP_RST)
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic enc_phase_a_in,
  input wire logic enc_phase_b_in,
  input wire logic alt_phase_a_in,
  input wire logic alt_phase_b_in,
  input wire logic index_in,
  output logic irq
);

  // ----------------------------------------------------------------
  // register state
  // ----------------------------------------------------------------
  ctrl_t ctrl_q;
  flags_t status_q;
  flags_t status_d;
  flags_t mask_q;
  flags_t events;
  count_t position_counter;
  count_t index_capture_reg;
  count_t periodic_capture_reg;
  count_t reference_counter;
  count_t period_compare_reg;
  count_t edge_capture_reg;
  count_t edge_capture_buffer;
  logic [31:0] prdata_q;
  logic [31:0] rd_mux;
  logic addr_hit;

  // ----------------------------------------------------------------
  // apb decode
  // ----------------------------------------------------------------
  logic setup_ph;
  logic access_ph;
  logic wr_en;
  logic rd_clr;

  assign setup_ph = psel & ~penable;
  assign access_ph = psel & penable;
  assign wr_en = access_ph & pwrite & addr_hit;
  assign rd_clr = access_ph & ~pwrite & (paddr == `OFS_STATUS);

  always_comb begin
    addr_hit = 1'b1;
    rd_mux = 32'h0000_0000;
    case (paddr)
      `OFS_CTRL: rd_mux = {29'h0000_0000, ctrl_q};
      `OFS_STATUS: rd_mux = {27'h0000_000, status_q};
      `OFS_MASK: rd_mux = {27'h0000_000, mask_q};
      `OFS_POSITION: rd_mux = {16'h0000, position_counter};
      `OFS_INDEX_CAP: rd_mux = {16'h0000, index_capture_reg};
      `OFS_PERIODIC_CAP: rd_mux = {16'h0000, periodic_capture_reg};
      `OFS_REFERENCE: rd_mux = {16'h0000, reference_counter};
      `OFS_PERIOD_CMP: rd_mux = {16'h0000, period_compare_reg};
      `OFS_EDGE_CAP: rd_mux = {16'h0000, edge_capture_reg};
      `OFS_EDGE_BUF: rd_mux = {16'h0000, edge_capture_buffer};
      default: addr_hit = 1'b0;
    endcase
  end

  // read data is sampled in the setup phase so it is a flop in the access phase
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      prdata_q <= 32'h0000_0000;
    end else if (setup_ph) begin
      prdata_q <= pwrite ? 32'h0000_0000 : rd_mux;
    end
  end

  assign prdata = prdata_q;
  assign pready = 1'b1;
  assign pslverr = access_ph & ~addr_hit;

  // byte lane merge for the writable registers
  function automatic logic [31:0] lane_merge(input logic [31:0] old_v,
                                             input logic [31:0] new_v,
                                             input logic [3:0] strb);
    logic [31:0] res;
    res = old_v;
    for (int i = 0; i < 4; i++) begin
      if (strb[i]) begin
        res[i*8 +: 8] = new_v[i*8 +: 8];
      end
    end
    return res;
  endfunction

  // ----------------------------------------------------------------
  // write merge
  // ----------------------------------------------------------------
  // each writable register merges the bus word over its own value, so
  // lanes left out of pstrb keep what they held
  logic [31:0] ctrl_wr;
  logic [31:0] mask_wr;
  logic [31:0] pcmp_wr;
  logic [31:0] pos_wr;

  assign ctrl_wr = lane_merge({29'h0000_0000, ctrl_q}, pwdata, pstrb);
  assign mask_wr = lane_merge({27'h0000_000, mask_q}, pwdata, pstrb);
  assign pcmp_wr = lane_merge({16'h0000, period_compare_reg}, pwdata, pstrb);
  assign pos_wr = lane_merge({16'h0000, position_counter}, pwdata, pstrb);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= ctrl_t'(`CTRL_RST);
      mask_q <= flags_t'(`FLAGS_RST);
    end else if (wr_en) begin
      if (paddr == `OFS_CTRL) begin
        ctrl_q <= ctrl_t'(ctrl_wr[`CTRL_W-1:0]);
      end
      if (paddr == `OFS_MASK) begin
        mask_q <= flags_t'(mask_wr[`FLAGS_W-1:0]);
      end
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      period_compare_reg <= PERIOD_CMP_RESET;
    end else if (wr_en && paddr == `OFS_PERIOD_CMP) begin
      period_compare_reg <= pcmp_wr[`CNT_W-1:0];
    end
  end

  // ----------------------------------------------------------------
  // reference timer
  // ----------------------------------------------------------------
  logic [7:0] div_q;
  logic ref_tick;
  logic ref_match;

  // one-cycle enable at the peripheral rate; no second clock needed
  assign ref_tick = (div_q == 8'(`REF_DIV - 1));

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      div_q <= 8'h00;
    end else if (!ctrl_q.ref_en || ref_tick) begin
      div_q <= 8'h00;
    end else begin
      div_q <= div_q + 8'h01;
    end
  end

  // a period written below the running count is only met after the counter
  // wraps through all ones; stopping the timer only holds the count and does not avoid the wrap
  assign ref_match = ctrl_q.ref_en & ref_tick & (reference_counter == period_compare_reg);

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      reference_counter <= '0;
    end else if (ctrl_q.ref_en && ref_tick) begin
      if (ref_match) begin
        reference_counter <= '0;
      end else begin
        reference_counter <= reference_counter + `CNT_W'(1);
      end
    end
  end

  // ----------------------------------------------------------------
  // quadrature decode
  // ----------------------------------------------------------------
  phase_t phase_now;
  phase_t phase_prev;
  step_t step;
  logic index_prev;
  logic index_rise;
  logic count_evt;
  logic wrap_up;
  logic wrap_down;

  // pins only; there is no prescaled source feeding the position counter
  assign phase_now = ctrl_q.alt_sel ? phase_t'({alt_phase_a_in, alt_phase_b_in})
                                    : phase_t'({enc_phase_a_in, enc_phase_b_in});

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      phase_prev <= '0;
      index_prev <= 1'b0;
    end else begin
      phase_prev <= phase_now;
      index_prev <= index_in;
    end
  end

  // both inputs moving at once carries no direction and is ignored
  always_comb begin
    step = '0;
    case ({phase_prev.a ^ phase_now.a, phase_prev.b ^ phase_now.b})
      2'b01: begin
        step.up = (phase_now.b == phase_now.a);
        step.down = (phase_now.b != phase_now.a);
      end
      2'b10: begin
        step.up = (phase_now.a != phase_now.b);
        step.down = (phase_now.a == phase_now.b);
      end
      default: step = '0;
    endcase
  end

  // a disabled counter must not fake an edge; a pin pair switch is not gated here and can
  assign count_evt = ctrl_q.pos_en & (step.up | step.down);
  assign index_rise = ctrl_q.pos_en & index_in & ~index_prev;
  assign wrap_up = count_evt & step.up & (position_counter == '1);
  assign wrap_down = count_evt & step.down & (position_counter == '0);

  // ----------------------------------------------------------------
  // position counter and captures
  // ----------------------------------------------------------------
  // the index clear wins over a count in the same cycle; capture sees the old count
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      position_counter <= '0;
    end else if (index_rise) begin
      position_counter <= '0;
    end else if (wr_en && paddr == `OFS_POSITION) begin
      position_counter <= pos_wr[`CNT_W-1:0];
    end else if (count_evt && step.up) begin
      position_counter <= position_counter + `CNT_W'(1);
    end else if (count_evt && step.down) begin
      position_counter <= position_counter - `CNT_W'(1);
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      index_capture_reg <= '0;
    end else if (index_rise) begin
      index_capture_reg <= position_counter;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      periodic_capture_reg <= '0;
    end else if (ref_match) begin
      periodic_capture_reg <= position_counter;
    end
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      edge_capture_reg <= '0;
      edge_capture_buffer <= '0;
    end else if (count_evt) begin
      edge_capture_reg <= reference_counter;
      edge_capture_buffer <= edge_capture_reg;
    end
  end

  // ----------------------------------------------------------------
  // interrupt status
  // ----------------------------------------------------------------
  always_comb begin
    events = '0;
    events.index = index_rise;
    events.periodic = ref_match;
    events.overflow = wrap_up & ~index_rise;
    events.underflow = wrap_down & ~index_rise;
    events.edge_cap = count_evt;
  end

  // only bits actually returned to software are cleared, so a set wins
  always_comb begin
    status_d = status_q;
    if (rd_clr) begin
      status_d = flags_t'(status_q & ~prdata_q[`FLAGS_W-1:0]);
    end
    status_d = flags_t'(status_d | events);
  end

  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      status_q <= flags_t'(`FLAGS_RST);
    end else begin
      status_q <= status_d;
    end
  end

  assign irq = |(status_q & mask_q);

endmodule

`default_nettype wire

/* File: test/qdec_asserts.sv */
`timescale 1ns/1ps
`default_nettype none
`include "qdec_params.svh"
module qdec_asserts
  import qdec_pkg::*;
#(
  parameter logic [`CNT_W-1:0] PERIOD_CMP_RESET = 16'h0009
) (
  input wire logic ref_clk,
  input wire logic rst_b,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [`ADDR_W-1:0] paddr,
  input wire logic [31:0] pwdata,
  input wire logic [3:0] pstrb,
  input wire logic [31:0] prdata,
  input wire logic pready,
  input wire logic pslverr,
  input wire logic enc_phase_a_in,
  input wire logic enc_phase_b_in,
  input wire logic alt_phase_a_in,
  input wire logic alt_phase_b_in,
  input wire logic index_in,
  input wire logic irq
);
  localparam int LIM = 2 * (int'(PERIOD_CMP_RESET) + 1) + 4;
  logic [2:0] ctrl_q;
  logic [4:0] mask_q;
  int gap_q;
  // shadow of control and mask; assumes full-word writes
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) begin
      ctrl_q <= 3'h0;
      mask_q <= 5'h00;
    end else if (psel && penable && pwrite && pready) begin
      if (paddr == 8'h00) ctrl_q <= pwdata[2:0];
      if (paddr == 8'h08) mask_q <= pwdata[4:0];
    end
  end
  always_ff @(posedge ref_clk or negedge rst_b) begin
    if (!rst_b) gap_q <= 0;
    else if (ctrl_q[2] && mask_q == 5'h02 && !irq) gap_q <= gap_q + 1;
    else gap_q <= 0;
  end
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_b);
  ready_a: assert property (psel && penable |-> pready)
    else $error("access phase without ready");
  unmapped_err_a: assert property (psel && penable && paddr > 8'h24 |-> pslverr)
    else $error("unmapped access not refused");
  read_width_a: assert property (psel && penable && !pwrite |-> prdata[31:16] == 16'h0000)
    else $error("read data wider than sixteen bits");
  mask_quiet_a: assert property (mask_q == 5'h00 |-> !irq)
    else $error("irq high with all events masked");
  index_irq_a: assert property (ctrl_q[0] && mask_q[0] && $rose(index_in) |-> ##[1:2] irq)
    else $error("index capture raised no irq");
  edge_irq_a: assert property (ctrl_q[0] && !ctrl_q[1] && mask_q[4] &&
    ($changed(enc_phase_a_in) != $changed(enc_phase_b_in)) |-> ##[1:2] irq)
    else $error("encoder edge raised no irq");
  alt_irq_a: assert property (ctrl_q[0] && ctrl_q[1] && mask_q[4] &&
    ($changed(alt_phase_a_in) != $changed(alt_phase_b_in)) |-> ##[1:2] irq)
    else $error("alternate pair edge raised no irq");
  period_gap_a: assert property (gap_q <= LIM)
    else $error("periodic capture overdue");
  cover property (irq);
  cover property (ctrl_q[0] && $rose(index_in));
  cover property (psel && penable && pslverr);
endmodule
`default_nettype wire

/* File: test/qdec_encoder_model.sv */
`timescale 1ns/1ps
`default_nettype none
module qdec_encoder_model (
  input wire logic ref_clk,
  output logic ph_a,
  output logic ph_b,
  output logic ph_z
);
  logic [1:0] pos_q;
  initial begin
    pos_q = 2'h0;
    ph_a = 1'b0;
    ph_b = 1'b0;
    ph_z = 1'b0;
  end
  // gray order, one line moves per step; gap sets how slow the shaft turns
  task automatic step(input logic up, input int gap);
    @(posedge ref_clk);
    pos_q = up ? pos_q + 2'h1 : pos_q - 2'h1;
    ph_a <= pos_q[1] ^ pos_q[0];
    ph_b <= pos_q[1];
    repeat (gap) @(posedge ref_clk);
  endtask
  task automatic pulse_index();
    @(posedge ref_clk);
    ph_z <= 1'b1;
    repeat (3) @(posedge ref_clk);
    ph_z <= 1'b0;
    repeat (2) @(posedge ref_clk);
  endtask
endmodule
`default_nettype wire

/* File: test/quadrature_counter_index_capture_bench.sv */
`timescale 1ns/1ps
`default_nettype none
module quadrature_counter_index_capture_bench;
  import qdec_pkg::*;
  localparam logic [15:0] PCMP = 16'h0009;
  logic ref_clk = 1'b0;
  logic rst_b = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [7:0] paddr = 8'h00;
  logic [31:0] pwdata = 32'h0;
  logic [3:0] pstrb = 4'hF;
  logic [31:0] prdata, rd_v, e1;
  logic pready, pslverr, irq, index_in, err_q;
  logic enc_phase_a_in, enc_phase_b_in, alt_phase_a_in, alt_phase_b_in;
  int n_mismatch = 0;
  int compares = 0;
  quadrature_counter_index_capture #(.PERIOD_CMP_RESET(PCMP))
    quadrature_counter_index_capture_i (.*);
  qdec_encoder_model enc (.ref_clk(ref_clk), .ph_a(enc_phase_a_in), .ph_b(enc_phase_b_in),
    .ph_z(index_in));
  qdec_encoder_model alt (.ref_clk(ref_clk), .ph_a(alt_phase_a_in), .ph_b(alt_phase_b_in),
    .ph_z());
  always #5 ref_clk = ~ref_clk;
  // ----------------------------------------
  // bus and checking tasks
  // ----------------------------------------
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    compares++;
    if (got !== exp) begin
      n_mismatch++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic close_out();
    $display("mismatches %0d, compares %0d", n_mismatch, compares);
    if (n_mismatch == 0 && compares > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask
  task automatic apb(input logic wr, input logic [7:0] ad, input logic [31:0] wd);
    int n;
    @(posedge ref_clk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= wr;
    paddr <= ad;
    pwdata <= wd;
    @(posedge ref_clk);
    penable <= 1'b1;
    for (n = 0; n < 16; n++) begin
      @(posedge ref_clk);
      if (pready === 1'b1) break;
    end
    if (n == 16) begin
      chk(32'h0, 32'h1);
      close_out();
    end
    rd_v = prdata;
    err_q = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd(input logic [7:0] ad, input logic [31:0] exp);
    apb(1'b0, ad, 32'h0);
    chk(rd_v, exp);
  endtask
  // ----------------------------------------
  // scenarios
  // ----------------------------------------
  task automatic s_regs();
    rd(8'h00, 32'h0);
    rd(8'h1C, {16'h0000, PCMP});
    rd(8'h30, 32'h0);
    chk({31'h0, err_q}, 32'h1);
  endtask
  task automatic s_count();
    apb(1'b1, 8'h00, 32'h1);
    apb(1'b1, 8'h08, 32'h1F);
    repeat (4) enc.step(1'b1, 3);
    rd(8'h0C, 32'h4);
    repeat (5) enc.step(1'b0, 3);
    rd(8'h0C, 32'hFFFF);
    enc.step(1'b1, 3);
    rd(8'h0C, 32'h0);
    chk({31'h0, irq}, 32'h1);
    rd(8'h04, 32'h1C);
    rd(8'h04, 32'h0);
  endtask
  task automatic s_index();
    repeat (3) enc.step(1'b1, 3);
    enc.pulse_index();
    rd(8'h10, 32'h3);
    rd(8'h0C, 32'h0);
    rd(8'h04, 32'h11);
  endtask
  task automatic s_edge();
    apb(1'b1, 8'h00, 32'h5);
    enc.step(1'b1, 7);
    apb(1'b0, 8'h20, 32'h0);
    e1 = rd_v;
    enc.step(1'b1, 3);
    rd(8'h24, e1);
    chk(32'(e1 <= 32'h9), 32'h1);
    rd(8'h04, 32'h10);
  endtask
  task automatic s_period();
    int n;
    apb(1'b1, 8'h08, 32'h2);
    apb(1'b0, 8'h04, 32'h0);
    for (n = 0; n < 60; n++) begin
      @(posedge ref_clk);
      if (irq === 1'b1) break;
    end
    chk(32'(n < 60), 32'h1);
    if (n == 60) begin
      close_out();
    end
    rd(8'h14, 32'h2);
    rd(8'h04, 32'h2);
  endtask
  task automatic s_alt();
    // park the main pair at 00 so the switch sees no phantom edge
    enc.step(1'b0, 3);
    apb(1'b1, 8'h08, 32'h1F);
    apb(1'b1, 8'h00, 32'h3);
    enc.step(1'b1, 3);
    repeat (2) alt.step(1'b1, 3);
    rd(8'h0C, 32'h3);
  endtask
  initial begin
    repeat (3) @(posedge ref_clk);
    rst_b <= 1'b1;
    s_regs();
    s_count();
    s_index();
    s_edge();
    s_period();
    s_alt();
    close_out();
  end
endmodule
bind quadrature_counter_index_capture qdec_asserts #(.PERIOD_CMP_RESET(PERIOD_CMP_RESET))
  qdec_asserts_i (.*);
`default_nettype wire
